// *** rtl/serial_flags.v ***
// Status flags, data register handshake and baud setting of the serial unit
`timescale 1ns/10ps
`default_nettype none
`include "serial_flags_defines.vh"

module serial_flags #(
	parameter ADDR_W = `ADDR_W,
	parameter DIV_W  = `DIV_W
) (
	// Clock and reset
	input  wire              i_clk,
	input  wire              i_rstn,
	// Register port
	input  wire [ADDR_W-1:0] i_addr,
	input  wire [15:0]       i_wdata,
	input  wire              i_word,
	input  wire              i_wr,
	input  wire              i_rd,
	output reg  [15:0]       o_rdata,
	// Shifter side
	input  wire              i_rx_done,
	input  wire [15:0]       i_rx_data,
	input  wire              i_tx_take,
	output reg  [15:0]       o_tx_data,
	output reg               o_tx_valid,
	// Select input and mode
	input  wire              i_ss_n,
	output reg               o_master,
	output reg               o_width_16,
	// Bit rate
	output wire [DIV_W-1:0]  o_divisor,
	output wire              o_baud_tick,
	// Interrupt
	output reg               o_irq
);

	// ==========================================================
	// Storage
	// ==========================================================
	reg [7:0]        ctrl1_q;
	reg [7:0]        ctrl2_q;
	reg [7:0]        baud_q;
	reg              rx_full_q;
	reg              tx_empty_q;
	reg              fault_q;
	// Arm bits remember a status read that saw the flag set; any flag change drops them
	reg              rx_armed_q;
	reg              tx_armed_q;
	reg              fault_armed_q;
	reg [15:0]       rx_q;
	reg [15:0]       rx_pend_q;
	reg              rx_pend_valid_q;
	reg [7:0]        tx_hi_q;
	reg [`IRQ_W-1:0] irq_stat_q;
	reg [`IRQ_W-1:0] irq_en_q;

	wire             width16;
	wire             fault_en;
	wire             master;
	wire             rd_status;
	wire             word16;
	wire             rd_lo;
	wire             wr_hi;
	wire             wr_lo;
	wire             wr_ctrl1;
	wire             wr_ctrl2;
	wire             wr_baud;
	wire             wr_irq_en;
	wire             wr_irq_clr;
	wire             rx_clear;
	wire             rx_load;
	wire             tx_hi_ok;
	wire             tx_load;
	wire             fault_set;
	wire             fault_clear;
	wire [7:0]       status;

	assign width16  = ctrl2_q[`CTRL2_WIDTH_BIT];
	assign fault_en = ctrl2_q[`CTRL2_FAULT_EN_BIT];
	assign master   = ctrl1_q[`CTRL1_MASTER_BIT];

	// ==========================================================
	// Access decode
	// ==========================================================
	// Access decode shared by every flag
	function hit;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	assign rd_status  = i_rd && hit(i_addr, `OFS_STATUS);
	// word access only joins bytes in 16-bit width
	assign word16     = i_word && width16;
	assign rd_lo      = i_rd && (hit(i_addr, `OFS_DATA_LO) || (word16 && hit(i_addr, `OFS_DATA_HI)));
	assign wr_hi      = i_wr && hit(i_addr, `OFS_DATA_HI);
	assign wr_lo      = i_wr && (hit(i_addr, `OFS_DATA_LO) || (word16 && hit(i_addr, `OFS_DATA_HI)));
	assign wr_ctrl1   = i_wr && hit(i_addr, `OFS_CTRL1);
	assign wr_ctrl2   = i_wr && hit(i_addr, `OFS_CTRL2);
	assign wr_baud    = i_wr && hit(i_addr, `OFS_BAUD);
	assign wr_irq_en  = i_wr && hit(i_addr, `OFS_IRQ_ENABLE);
	assign wr_irq_clr = i_wr && hit(i_addr, `OFS_IRQ_CLEAR);

	// Spare status bits read as zero
	assign status = {rx_full_q, 1'b0, tx_empty_q, fault_q, 4'h0};

	// ==========================================================
	// Receive path
	// ==========================================================
	// clear after qualifying low read
	// high byte reads leave the flag
	assign rx_clear = rd_lo && rx_armed_q && rx_full_q;
	// Data held back while the flag is set moves in once it clears
	assign rx_load = (i_rx_done || rx_pend_valid_q) && (!rx_full_q || rx_clear);

	always @(posedge i_clk) begin
		if (!i_rstn) begin
			rx_full_q       <= 1'b0;
			rx_armed_q      <= 1'b0;
			rx_q            <= 16'h0000;
			rx_pend_q       <= 16'h0000;
			rx_pend_valid_q <= 1'b0;
		end else begin
			if (rx_load) begin
				// set on transfer into data register
				rx_full_q       <= 1'b1;
				rx_q            <= rx_pend_valid_q ? rx_pend_q : i_rx_data;
				rx_pend_valid_q <= rx_pend_valid_q && i_rx_done;
				if (rx_pend_valid_q && i_rx_done)
					rx_pend_q <= i_rx_data;
			end else begin
				if (rx_clear)
					rx_full_q <= 1'b0;
				// Single holding slot: a third reception while unserviced is dropped
				if (i_rx_done && !rx_pend_valid_q) begin
					rx_pend_q       <= i_rx_data;
					rx_pend_valid_q <= 1'b1;
				end
			end
			if (rx_load || rx_clear)
				rx_armed_q <= 1'b0;
			else if (rd_status && rx_full_q)
				rx_armed_q <= 1'b1;
		end
	end

	// ==========================================================
	// Transmit path
	// ==========================================================
	// High byte waits in its own register until a low write in 16-bit width commits the frame; a word write sends its own high byte
	// writes ignored while not empty
	assign tx_hi_ok = wr_hi && tx_empty_q && !word16;
	// low write needs prior status read
	// only low or word write clears
	assign tx_load = wr_lo && tx_empty_q && tx_armed_q;

	always @(posedge i_clk) begin
		if (!i_rstn) begin
			tx_empty_q <= 1'b1;
			tx_armed_q <= 1'b0;
			tx_hi_q    <= 8'h00;
			o_tx_data  <= 16'h0000;
			o_tx_valid <= 1'b0;
		end else begin
			if (tx_hi_ok)
				tx_hi_q <= i_wdata[7:0];
			if (tx_load) begin
				tx_empty_q <= 1'b0;
				o_tx_valid <= 1'b1;
				// 8-bit width sends the low byte only
				if (!width16)
					o_tx_data <= {8'h00, i_wdata[7:0]};
				else if (word16)
					o_tx_data <= i_wdata;
				else
					o_tx_data <= {tx_hi_q, i_wdata[7:0]};
			end else if (i_tx_take && !tx_empty_q) begin
				// empty again once shifter takes it
				tx_empty_q <= 1'b1;
				o_tx_valid <= 1'b0;
			end
			if (tx_load || !tx_empty_q)
				tx_armed_q <= 1'b0;
			else if (rd_status && tx_empty_q)
				tx_armed_q <= 1'b1;
		end
	end

	// ==========================================================
	// Mode fault and control registers
	// ==========================================================
	// select low while master with detection
	assign fault_set = master && fault_en && !i_ss_n;
	assign fault_clear = wr_ctrl1 && fault_armed_q;

	// A fault drops master mode and wins over a same-cycle control write
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			ctrl1_q <= `CTRL1_RESET;
		end else begin
			if (wr_ctrl1)
				ctrl1_q <= i_wdata[7:0];
			if (fault_set)
				ctrl1_q[`CTRL1_MASTER_BIT] <= 1'b0;
		end
	end

	// Reserved bits of the second control and baud registers stay zero
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			ctrl2_q <= `CTRL2_RESET;
			baud_q  <= `BAUD_RESET;
		end else begin
			if (wr_ctrl2)
				ctrl2_q <= i_wdata[7:0] & `CTRL2_WMASK;
			if (wr_baud)
				baud_q <= i_wdata[7:0] & `BAUD_WMASK;
		end
	end

	// Set wins over a clear in the same cycle
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			fault_q       <= 1'b0;
			fault_armed_q <= 1'b0;
		end else begin
			if (fault_set)
				fault_q <= 1'b1;
			else if (fault_clear)
				fault_q <= 1'b0;
			if (fault_set || fault_clear)
				fault_armed_q <= 1'b0;
			else if (rd_status && fault_q)
				fault_armed_q <= 1'b1;
		end
	end

	// Mode outputs follow the control bits one cycle later, except a fault drops o_master in the same cycle as the master bit
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			o_master   <= 1'b0;
			o_width_16 <= 1'b0;
		end else begin
			o_master   <= master && !fault_set;
			o_width_16 <= width16;
		end
	end

	// ==========================================================
	// Interrupt status, enable and clear
	// ==========================================================
	wire [`IRQ_W-1:0] irq_event;
	wire [`IRQ_W-1:0] irq_clear;
	reg               rx_full_d1_q;
	reg               tx_empty_d1_q;

	assign irq_event = {fault_set && !fault_q,
	                    tx_empty_q && !tx_empty_d1_q,
	                    rx_full_q && !rx_full_d1_q};
	assign irq_clear = wr_irq_clr ? i_wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

	always @(posedge i_clk) begin
		if (!i_rstn) begin
			irq_stat_q    <= {`IRQ_W{1'b0}};
			irq_en_q      <= {`IRQ_W{1'b0}};
			rx_full_d1_q  <= 1'b0;
			tx_empty_d1_q <= 1'b1;
			o_irq         <= 1'b0;
		end else begin
			rx_full_d1_q  <= rx_full_q;
			tx_empty_d1_q <= tx_empty_q;
			// New events win over a clear in the same cycle
			irq_stat_q    <= (irq_stat_q & ~irq_clear) | irq_event;
			if (wr_irq_en)
				irq_en_q <= i_wdata[`IRQ_W-1:0];
			o_irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// ==========================================================
	// Read data
	// ==========================================================
	reg [15:0] rdata_d;

	always @* begin
		rdata_d = 16'h0000;
		case (i_addr)
			`OFS_CTRL1:      rdata_d = {8'h00, ctrl1_q};
			`OFS_CTRL2:      rdata_d = {8'h00, ctrl2_q};
			`OFS_BAUD:       rdata_d = {8'h00, baud_q};
			`OFS_STATUS:     rdata_d = {8'h00, status};
			`OFS_DATA_HI:    rdata_d = word16 ? rx_q : {8'h00, rx_q[15:8]};
			`OFS_DATA_LO:    rdata_d = {8'h00, rx_q[7:0]};
			`OFS_IRQ_STATUS: rdata_d = {{(16-`IRQ_W){1'b0}}, irq_stat_q};
			`OFS_IRQ_ENABLE: rdata_d = {{(16-`IRQ_W){1'b0}}, irq_en_q};
			default:         rdata_d = 16'h0000;
		endcase
	end

	// Read data stands one cycle only, so a stale value never looks like a fresh read
	always @(posedge i_clk) begin
		if (!i_rstn)
			o_rdata <= 16'h0000;
		else if (i_rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= 16'h0000;
	end

	// ==========================================================
	// Bit-rate generator
	// ==========================================================
	// Only a running master transfer clocks the divider, so the rate rests between frames
	// divisor from baud fields
	baud_divider #(
		.DIV_W(DIV_W)
	) u_baud (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_preselect(baud_q[`BAUD_PRE_HI:`BAUD_PRE_LO]),
		.i_select   (baud_q[`BAUD_SEL_HI:`BAUD_SEL_LO]),
		.i_run      (o_master && o_tx_valid),
		.o_divisor  (o_divisor),
		.o_tick     (o_baud_tick)
	);

endmodule
`default_nettype wire

// *** shared/serial_flags_defines.vh ***
// Register map, field positions and reset values of the serial flag and baud block
`ifndef SERIAL_FLAGS_DEFINES_VH
`define SERIAL_FLAGS_DEFINES_VH

// Register offsets
`define ADDR_W              4
`define OFS_CTRL1           4'h0
`define OFS_CTRL2           4'h1
`define OFS_BAUD            4'h2
`define OFS_STATUS          4'h3
`define OFS_DATA_HI         4'h4
`define OFS_DATA_LO         4'h5
`define OFS_IRQ_STATUS      4'h6
`define OFS_IRQ_ENABLE      4'h7
`define OFS_IRQ_CLEAR       4'h8

// First control register fields
`define CTRL1_MASTER_BIT    4
// Second control register fields
`define CTRL2_WIDTH_BIT     6
`define CTRL2_FAULT_EN_BIT  4
`define CTRL2_WMASK         8'h5B
// Baud register fields
`define BAUD_PRE_HI         6
`define BAUD_PRE_LO         4
`define BAUD_SEL_HI         2
`define BAUD_SEL_LO         0
`define BAUD_WMASK          8'h77

// Status register fields
`define STAT_RX_FULL_BIT    7
`define STAT_TX_EMPTY_BIT   5
`define STAT_FAULT_BIT      4

// Interrupt status layout
`define IRQ_RX_BIT          0
`define IRQ_TX_BIT          1
`define IRQ_FAULT_BIT       2
`define IRQ_W               3

// Reset values
`define CTRL1_RESET         8'h04
`define CTRL2_RESET         8'h00
`define BAUD_RESET          8'h00
`define DIV_W               12

`endif

// *** rtl/baud_divider.v ***
// Serial clock divisor and bit-rate tick generator
`timescale 1ns/10ps
`default_nettype none
`include "serial_flags_defines.vh"

module baud_divider #(
	parameter DIV_W = `DIV_W
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rstn,
	// Baud fields and run request
	input  wire [2:0]       i_preselect,
	input  wire [2:0]       i_select,
	input  wire             i_run,
	// Divisor and tick
	output reg  [DIV_W-1:0] o_divisor,
	output reg              o_tick
);

	// ==========================================================
	// Divisor arithmetic
	// ==========================================================
	// divisor formula
	function [DIV_W-1:0] calc_divisor;
		input [2:0] pre;
		input [2:0] sel;
		begin
			// Shift amount kept four bits wide so select 7 gives a shift of 8, not 0
			calc_divisor = ({{(DIV_W-3){1'b0}}, pre} + 1'b1) << ({1'b0, sel} + 4'h1);
		end
	endfunction

	wire [DIV_W-1:0] divisor_d;
	reg  [DIV_W-1:0] count_q;

	assign divisor_d = calc_divisor(i_preselect, i_select);

	// ==========================================================
	// Counter
	// ==========================================================
	// Idle restarts the count so each frame starts on a full period
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			o_divisor <= {DIV_W{1'b0}};
			count_q   <= {DIV_W{1'b0}};
			o_tick    <= 1'b0;
		end else begin
			o_divisor <= divisor_d;
			if (!i_run || divisor_d != o_divisor) begin
				count_q <= {DIV_W{1'b0}};
				o_tick  <= 1'b0;
			end else if (count_q == o_divisor - 1'b1) begin
				count_q <= {DIV_W{1'b0}};
				o_tick  <= 1'b1;
			end else begin
				count_q <= count_q + 1'b1;
				o_tick  <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// *** tb/serial_flags_chk.sv ***
// Port assertions for the serial flag block
`timescale 1ns/10ps
`default_nettype none
`include "serial_flags_defines.vh"
module serial_flags_chk #(
	parameter ADDR_W = 4,
	parameter DIV_W  = 12
) (
	// Clock, reset, bus
	input wire logic              i_clk,
	input wire logic              i_rstn,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [15:0]       i_wdata,
	input wire logic              i_word,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [15:0]       o_rdata,
	// Shifter, mode, rate
	input wire logic              i_tx_take,
	input wire logic [15:0]       o_tx_data,
	input wire logic              o_tx_valid,
	input wire logic              i_ss_n,
	input wire logic              o_master,
	input wire logic [DIV_W-1:0]  o_divisor,
	input wire logic              o_baud_tick
);
	// ==========================================
	// Checks
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	wire lo_wr = i_wr && (i_addr == `OFS_DATA_LO || (i_addr == `OFS_DATA_HI && i_word));
	wire ctl_wr = i_wr && i_addr == `OFS_CTRL1;
	sequence s_stat_rd;
		i_rd && i_addr == `OFS_STATUS;
	endsequence
	a_read_idle: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("read data left up");
	a_stat_empty: assert property (s_stat_rd |=> o_rdata[5] == !$past(o_tx_valid)) else $error("empty bit wrong");
	a_tx_fill: assert property ($rose(o_tx_valid) |-> $past(lo_wr)) else $error("filled without low write");
	a_tx_low8: assert property ($rose(o_tx_valid) |-> o_tx_data[7:0] == $past(i_wdata[7:0])) else $error("tx low");
	a_tx_drain: assert property ($fell(o_tx_valid) |-> $past(i_tx_take)) else $error("emptied by itself");
	a_tx_hold: assert property (o_tx_valid && !i_tx_take && i_wr |=> $stable(o_tx_data)) else $error("full wr");
	a_fault_drop: assert property ($fell(o_master) |-> !$past(i_ss_n) || $past(ctl_wr, 2)) else $error("master lost");
	a_div_range: assert property ($past(i_rstn, 2) |-> o_divisor >= 2 && o_divisor <= 2048 && !o_divisor[0])
		else $error("divisor out of range");
	a_tick_gate: assert property (o_baud_tick |-> $past(o_master && o_tx_valid)) else $error("tick while idle");
endmodule
bind serial_flags serial_flags_chk #(.ADDR_W(ADDR_W), .DIV_W(DIV_W)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_word(i_word), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_tx_take(i_tx_take), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .i_ss_n(i_ss_n),
	.o_master(o_master), .o_divisor(o_divisor), .o_baud_tick(o_baud_tick));
`default_nettype wire

// *** tb/shifter_model.sv ***
// Shifter stand-in: shifts the word out on ticks and answers with its complement
`timescale 1ns/10ps
`default_nettype none
module shifter_model (
	// Clock and width
	input  wire logic        i_clk,
	input  wire logic        i_width_16,
	// Transmit side
	input  wire logic        i_tx_valid,
	input  wire logic [15:0] i_tx_data,
	input  wire logic        i_tick,
	// Answer side
	output logic             o_rx_done,
	output logic [15:0]      o_rx_data,
	output logic             o_tx_take
);
	// ==========================================
	// Frame
	int bits = 0;
	initial o_rx_done = 1'b0;
	initial o_tx_take = 1'b0;
	initial o_rx_data = 16'hA5A5;
	always @(posedge i_clk) begin
		o_tx_take <= 1'b0;
		o_rx_done <= 1'b0;
		// Data is only valid with the done pulse, so keep it moving
		o_rx_data <= ~o_rx_data;
		if (i_tx_valid && i_tick)
			bits = bits + 1;
		if (bits >= (i_width_16 ? 16 : 8)) begin
			bits = 0;
			o_tx_take <= 1'b1;
			o_rx_done <= 1'b1;
			o_rx_data <= i_width_16 ? ~i_tx_data : {8'h00, ~i_tx_data[7:0]};
		end
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the serial flag and baud block
`timescale 1ns/10ps
`default_nettype none
`include "serial_flags_defines.vh"
module testbench;
	// ==========================================
	// Signals
	logic        i_clk = 1'b0, i_rstn = 1'b0, i_word = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_ss_n = 1'b1;
	logic [3:0]  i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000, o_rdata, i_rx_data, o_tx_data, r, txd;
	logic        i_rx_done, i_tx_take, o_tx_valid, o_master, o_width_16, o_baud_tick, o_irq;
	logic [11:0] o_divisor, dv;
	logic [3:0]  st;
	int          n_mismatch = 0, tests_run = 0;
	// Baud register value beside the divisor it gives
	logic [7:0]  baud_in [10] = '{8'h00, 8'h01, 8'h07, 8'h10, 8'h27, 8'h40, 8'h47, 8'h60, 8'h57, 8'hFF};
	logic [11:0] div_exp [10] = '{12'h002, 12'h004, 12'h100, 12'h004, 12'h300, 12'h00A, 12'h500, 12'h00E,
		12'h600, 12'h800};
	always #5 i_clk = ~i_clk;
	serial_flags uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_word(i_word),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_done(i_rx_done), .i_rx_data(i_rx_data),
		.i_tx_take(i_tx_take), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .i_ss_n(i_ss_n),
		.o_master(o_master), .o_width_16(o_width_16), .o_divisor(o_divisor), .o_baud_tick(o_baud_tick),
		.o_irq(o_irq));
	shifter_model far (.i_clk(i_clk), .i_width_16(o_width_16), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
		.i_tick(o_baud_tick), .o_rx_done(i_rx_done), .o_rx_data(i_rx_data), .o_tx_take(i_tx_take));
	task chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// A gap cycle after each write keeps the strobe from being set twice in one step
	task wr(input logic [3:0] a, input logic [15:0] d, input logic w);
		i_addr <= a;
		i_wdata <= d;
		i_word <= w;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task rd(input logic [3:0] a, input logic w, output logic [15:0] v);
		i_addr <= a;
		i_word <= w;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		v = o_rdata;
		@(posedge i_clk);
	endtask
	task snap;
		@(negedge i_clk);
		st = {o_width_16, o_irq, o_master, o_tx_valid};
		txd = o_tx_data;
		dv = o_divisor;
		@(posedge i_clk);
	endtask
	task poll;
		r = 16'h0000;
		for (int n = 0; n < 100 && r[7] !== 1'b1; n++)
			rd(`OFS_STATUS, 1'b0, r);
		chk(r[7], 1'b1);
	endtask
	task end_sim;
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================
	// Sequence
	initial begin
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		wr(`OFS_DATA_LO, 16'h0011, 1'b0);
		snap;
		chk(st[0], 1'b0);
		chk(st[3], 1'b0);
		wr(`OFS_STATUS, 16'h00FF, 1'b0);
		rd(`OFS_STATUS, 1'b0, r);
		chk(r, 16'h0020);
		rd(4'hF, 1'b0, r);
		chk(r, 16'h0000);
		for (int k = 0; k < 10; k++) begin
			wr(`OFS_BAUD, {8'h00, baud_in[k]}, 1'b0);
			rd(`OFS_BAUD, 1'b0, r);
			snap;
			chk(dv, div_exp[k]);
			chk(r, {8'h00, baud_in[k] & `BAUD_WMASK});
		end
		wr(`OFS_BAUD, 16'h0000, 1'b0);
		wr(`OFS_CTRL1, 16'h0014, 1'b0);
		wr(`OFS_CTRL2, 16'h0010, 1'b0);
		wr(`OFS_IRQ_ENABLE, 16'h0001, 1'b0);
		wr(`OFS_DATA_LO, 16'h00A5, 1'b0);
		wr(`OFS_DATA_LO, 16'h005A, 1'b0);
		snap;
		chk(st[0], 1'b1);
		chk(txd, 16'h00A5);
		poll;
		snap;
		chk(st[2], 1'b1);
		rd(`OFS_DATA_LO, 1'b0, r);
		chk(r, 16'h005A);
		rd(`OFS_STATUS, 1'b0, r);
		chk(r, 16'h0020);
		wr(`OFS_IRQ_CLEAR, 16'h0001, 1'b0);
		wr(`OFS_IRQ_ENABLE, 16'h0000, 1'b0);
		snap;
		chk(st[2], 1'b0);
		wr(`OFS_CTRL2, 16'h0050, 1'b0);
		wr(`OFS_DATA_HI, 16'h0012, 1'b0);
		snap;
		chk(st[0], 1'b0);
		chk(st[3], 1'b1);
		wr(`OFS_DATA_LO, 16'h0034, 1'b0);
		snap;
		chk(txd, 16'h1234);
		poll;
		rd(`OFS_DATA_HI, 1'b0, r);
		rd(`OFS_DATA_HI, 1'b0, r);
		chk(r, 16'h00ED);
		rd(`OFS_STATUS, 1'b0, r);
		chk(r, 16'h00A0);
		rd(`OFS_DATA_LO, 1'b0, r);
		chk(r, 16'h00CB);
		snap;
		chk(st[2], 1'b0);
		wr(`OFS_DATA_HI, 16'hBEEF, 1'b1);
		snap;
		chk(txd, 16'hBEEF);
		poll;
		rd(`OFS_DATA_HI, 1'b1, r);
		chk(r, 16'h4110);
		rd(`OFS_STATUS, 1'b0, r);
		chk(r, 16'h0020);
		i_ss_n <= 1'b0;
		@(posedge i_clk);
		i_ss_n <= 1'b1;
		snap;
		chk(st[1], 1'b0);
		wr(`OFS_CTRL1, 16'h0014, 1'b0);
		rd(`OFS_STATUS, 1'b0, r);
		chk(r, 16'h0030);
		wr(`OFS_CTRL1, 16'h0014, 1'b0);
		rd(`OFS_STATUS, 1'b0, r);
		chk(r, 16'h0020);
		end_sim;
	end
	// The run needs under a thousand cycles
	initial begin
		#100000;
		n_mismatch++;
		end_sim;
	end
endmodule
`default_nettype wire
